/* File: shared/gpio_pkg.sv */
package gpio_pkg;
    // Bus geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_PORT_TWO_DATA = 16'hFF02;
    localparam logic [15:0] IDX_PORT_THREE_DATA = 16'hFF03;
    localparam logic [15:0] IDX_PORT_FOUR_DATA = 16'hFF04;
    localparam logic [15:0] IDX_PORT_TWO_DIRECTION = 16'hFF22;
    localparam logic [15:0] IDX_PORT_THREE_DIRECTION = 16'hFF23;
    localparam logic [15:0] IDX_PORT_FOUR_DIRECTION = 16'hFF24;
    localparam logic [15:0] IDX_PORT_TWO_PULLUP_ENABLE = 16'hFF32;
    localparam logic [15:0] IDX_PORT_THREE_PULLUP_ENABLE = 16'hFF33;
    localparam logic [15:0] IDX_PORT_FOUR_PULLUP_ENABLE = 16'hFF34;
    localparam logic [15:0] IDX_PIN_CONFIG_STATUS = 16'hFF40;
    // Reset values
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] PU_RST = 8'h00;
    // Field positions
    localparam int P3_IO_BIT = 2;
    localparam int P3_RST_BIT = 4;
    localparam int OPT_CLK_LSB = 0;
    localparam int OPT_RSTPIN_PORT_BIT = 2;
    localparam int STAT_CLK_LSB = 0;
    localparam int STAT_RSTPIN_PORT_BIT = 2;
    localparam int STAT_RUN_BIT = 3;
    // Clock source codes carried in the option byte
    localparam logic [1:0] CLK_SRC_HSI = 2'h0;
    localparam logic [1:0] CLK_SRC_XTAL = 2'h1;
    localparam logic [1:0] CLK_SRC_EXT = 2'h2;
    // Port two bits left to the port per clock source
    localparam logic [3:0] P2_MASK_HSI = 4'hF;
    localparam logic [3:0] P2_MASK_XTAL = 4'h3;
    localparam logic [3:0] P2_MASK_EXT = 4'h7;
    // Option byte sequencing after reset release
    typedef enum logic {
        OPT_WAIT,
        OPT_RUN
    } opt_e;
endpackage

/* File: hw/three_port_gpio.sv */
// What this block does
// - First port has four bits, each with latch and direction bit.
// - First port input bits connect pull-up when their enable bit is set.
// - Internal oscillator selected: first port bits 2 and 3 are ordinary I/O.
// - Crystal oscillator selected: first port bits 2 and 3 belong to oscillator.
// - External clock selected: bit 2 stays I/O, bit 3 is clock input only.
// - Second port bit 2 is bidirectional with latch, direction, pull-up; interrupt input.
// - Second port bit 4 is input only, shared with reset; option byte chooses.
// - Option byte read after reset release; low shared pin before keeps reset.
// - Shared pin configured as port input is ignored as reset source.
// - Third port has eight bits with latch, direction and pull-up enable.
// - Direction bit 0 turns output buffer on, 1 turns it off.
// - Reset sets all direction registers to ones, every bit input.
// - Direction and data registers accept full-byte writes, single bits by merge.
// - Data read returns pin level for inputs, latch value for outputs.
// - Reset clears all output latches to zero.
// - Second port bit 4 data is read-only and reflects the pin.
// - Latch 0 drives low, 1 drives high; low pin reads 0, high reads 1.
// - Interrupt-shared bits in output mode raise request when driven level changes.
// - Latch writes in input mode are kept, pin stays undriven.
// - Pull-up enable 1 connects, 0 disconnects; enables reset to zero.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module three_port_gpio (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Option byte from nonvolatile store, stable after reset
    input wire logic [7:0] option_byte,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
    input wire logic [gpio_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [gpio_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // First port pins
    input wire logic [3:0] port_two_pin_in,
    output logic [3:0] port_two_pin_out,
    output logic [3:0] port_two_pin_oe,
    output logic [3:0] port_two_pullup_en,
    // Second port pins
    input wire logic second_port_io_in,
    output logic second_port_io_out,
    output logic second_port_io_oe,
    output logic second_port_io_pullup_en,
    input wire logic shared_reset_input_in,
    // Third port pins
    input wire logic [7:0] port_four_pin_in,
    output logic [7:0] port_four_pin_out,
    output logic [7:0] port_four_pin_oe,
    output logic [7:0] port_four_pullup_en,
    // System side
    output logic ext_irq_first_req,
    output logic ext_irq_second_req,
    output logic system_reset_hold,
    output logic [1:0] clock_source
);
    import gpio_pkg::*;

    typedef struct packed {
        logic [3:0] lat2;
        logic lat3;
        logic [7:0] lat4;
        logic [3:0] dir2;
        logic dir3;
        logic [7:0] dir4;
        logic [3:0] pu2;
        logic pu3;
        logic [7:0] pu4;
        logic [13:0] sync1;
        logic [13:0] sync2;
        logic [3:0] oe2;
        logic oe3;
        logic [7:0] oe4;
        logic [3:0] pe2;
        logic pe3;
        logic [7:0] pe4;
        opt_e opt;
        logic [1:0] clk_src;
        logic rst_is_port;
        logic hold;
        logic [1:0] irq;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic err;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic [13:0] pins_raw;
    logic [3:0] p2_pin;
    logic p32_pin;
    logic p34_pin;
    logic [7:0] p4_pin;
    logic [3:0] p2_mask;
    logic [15:0] idx;
    logic hit;
    logic [7:0] rd_byte;
    logic wr_en;
    logic [7:0] wb;
    logic lvl1_prev;
    logic lvl2_prev;

    // Raw pins in one vector, so one pair of stages serves them all
    assign pins_raw = {port_four_pin_in, shared_reset_input_in, second_port_io_in,
                       port_two_pin_in};
    assign idx = paddr[ADDR_W-1:2];

    // Synchronised pin levels; only the second stage is ever looked at
    always_comb begin
        p2_pin = s_q.sync2[3:0];
        p32_pin = s_q.sync2[4];
        p34_pin = s_q.sync2[5];
        p4_pin = s_q.sync2[13:6];
    end

    // Bits of the first port the clock source leaves to the port
    always_comb begin
        case (s_q.clk_src)
            CLK_SRC_XTAL: p2_mask = P2_MASK_XTAL;
            CLK_SRC_EXT: p2_mask = P2_MASK_EXT;
            default: p2_mask = P2_MASK_HSI;
        endcase
    end

    // Address decode and read data; unaligned or unknown words are errors
    always_comb begin
        hit = (paddr[1:0] == 2'h0);
        rd_byte = 8'h00;
        case (idx)
            IDX_PORT_TWO_DATA: rd_byte = {4'h0, p2_mask & ((s_q.dir2 & p2_pin)
                | (~s_q.dir2 & s_q.lat2))};
            IDX_PORT_THREE_DATA: begin
                rd_byte[P3_RST_BIT] = p34_pin;
                rd_byte[P3_IO_BIT] = s_q.dir3 ? p32_pin : s_q.lat3;
            end
            IDX_PORT_FOUR_DATA: rd_byte = (s_q.dir4 & p4_pin)
                | (~s_q.dir4 & s_q.lat4);
            IDX_PORT_TWO_DIRECTION: rd_byte = {4'hF, s_q.dir2};
            IDX_PORT_THREE_DIRECTION: begin
                rd_byte = 8'hFF;
                rd_byte[P3_IO_BIT] = s_q.dir3;
            end
            IDX_PORT_FOUR_DIRECTION: rd_byte = s_q.dir4;
            IDX_PORT_TWO_PULLUP_ENABLE: rd_byte = {4'h0, s_q.pu2};
            IDX_PORT_THREE_PULLUP_ENABLE: rd_byte[P3_IO_BIT] = s_q.pu3;
            IDX_PORT_FOUR_PULLUP_ENABLE: rd_byte = s_q.pu4;
            IDX_PIN_CONFIG_STATUS: begin
                rd_byte[STAT_CLK_LSB +: 2] = s_q.clk_src;
                rd_byte[STAT_RSTPIN_PORT_BIT] = s_q.rst_is_port;
                rd_byte[STAT_RUN_BIT] = (s_q.opt == OPT_RUN);
            end
            default: hit = 1'b0;
        endcase
    end

    // Write lands at the edge where the master sees pready
    // Low strobe clear drops the write; upper bytes carry nothing
    assign wr_en = psel && penable && pwrite && s_q.ready && !s_q.err && pstrb[0];
    assign wb = pwdata[7:0];

    // Level last seen on each interrupt-shared pin
    assign lvl1_prev = s_q.oe2[1] ? s_q.lat2[1] : p2_pin[1];
    assign lvl2_prev = s_q.oe3 ? s_q.lat3 : p32_pin;

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.sync1 = pins_raw;
        s_d.sync2 = s_q.sync1;
        s_d.ready = 1'b0;
        s_d.err = 1'b0;
        s_d.irq = 2'h0;
        // One wait state so read data comes from a flop
        if (psel && penable && !s_q.ready) begin
            s_d.ready = 1'b1;
            s_d.err = !hit;
            s_d.rdata = {24'h0, rd_byte};
        end
        // Whole-byte writes; bit writes are merged by software read-modify-write
        if (wr_en) begin
            case (idx)
                IDX_PORT_TWO_DATA: s_d.lat2 = wb[3:0];
                IDX_PORT_THREE_DATA: s_d.lat3 = wb[P3_IO_BIT];
                IDX_PORT_FOUR_DATA: s_d.lat4 = wb;
                IDX_PORT_TWO_DIRECTION: s_d.dir2 = wb[3:0];
                IDX_PORT_THREE_DIRECTION: s_d.dir3 = wb[P3_IO_BIT];
                IDX_PORT_FOUR_DIRECTION: s_d.dir4 = wb;
                IDX_PORT_TWO_PULLUP_ENABLE: s_d.pu2 = wb[3:0];
                IDX_PORT_THREE_PULLUP_ENABLE: s_d.pu3 = wb[P3_IO_BIT];
                IDX_PORT_FOUR_PULLUP_ENABLE: s_d.pu4 = wb;
                default: ;
            endcase
        end
        // Option byte is taken only once the shared pin has gone high
        case (s_q.opt)
            OPT_WAIT: begin
                if (p34_pin) begin
                    s_d.opt = OPT_RUN;
                    s_d.clk_src = option_byte[OPT_CLK_LSB +: 2];
                    s_d.rst_is_port = option_byte[OPT_RSTPIN_PORT_BIT];
                end
            end
            OPT_RUN: s_d.opt = OPT_RUN;
            default: s_d.opt = OPT_WAIT;
        endcase
        // Reset request: held before the option read, then pin only in reset role
        s_d.hold = (s_d.opt == OPT_WAIT) || (!s_d.rst_is_port && !p34_pin);
        // Buffers and pull-ups; pins given to the oscillator stay quiet
        // Mask lags a capture by one edge; harmless, directions are still inputs then
        s_d.oe2 = ~s_d.dir2 & p2_mask;
        s_d.oe3 = !s_d.dir3;
        s_d.oe4 = ~s_d.dir4;
        s_d.pe2 = s_d.pu2 & s_d.dir2 & p2_mask;
        s_d.pe3 = s_d.pu3 && s_d.dir3;
        s_d.pe4 = s_d.pu4 & s_d.dir4;
        // Driven level change on interrupt-shared bits raises a request
        s_d.irq[0] = s_d.oe2[1] && (s_d.lat2[1] != lvl1_prev);
        s_d.irq[1] = s_d.oe3 && (s_d.lat3 != lvl2_prev);
    end

    // State register; reset restores all software-visible controls
    // Sync stages clear too, so the first pin sample lands two edges after release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.lat2 <= LATCH_RST[3:0];
            s_q.lat3 <= LATCH_RST[0];
            s_q.lat4 <= LATCH_RST;
            s_q.dir2 <= DIR_RST[3:0];
            s_q.dir3 <= DIR_RST[0];
            s_q.dir4 <= DIR_RST;
            s_q.pu2 <= PU_RST[3:0];
            s_q.pu3 <= PU_RST[0];
            s_q.pu4 <= PU_RST;
            s_q.opt <= OPT_WAIT;
            s_q.clk_src <= CLK_SRC_HSI;
            s_q.hold <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from state flops
    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign port_two_pin_out = s_q.lat2;
    assign port_two_pin_oe = s_q.oe2;
    assign port_two_pullup_en = s_q.pe2;
    assign second_port_io_out = s_q.lat3;
    assign second_port_io_oe = s_q.oe3;
    assign second_port_io_pullup_en = s_q.pe3;
    assign port_four_pin_out = s_q.lat4;
    assign port_four_pin_oe = s_q.oe4;
    assign port_four_pullup_en = s_q.pe4;
    assign ext_irq_first_req = s_q.irq[0];
    assign ext_irq_second_req = s_q.irq[1];
    assign system_reset_hold = s_q.hold;
    assign clock_source = s_q.clk_src;

    // Checks
    property p_dir_reset;
        @(posedge clk) $fell(sys_rst) |-> (s_q.dir4 == 8'hFF) && (s_q.dir2 == 4'hF)
            && s_q.dir3;
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction not all input after reset");

    property p_latch_reset;
        @(posedge clk) $fell(sys_rst) |-> (s_q.lat4 == 8'h00) && (s_q.lat2 == 4'h0);
    endproperty
    a_latch_reset: assert property (p_latch_reset)
        else $error("latch not cleared by reset");

    property p_oe_follows_dir;
        @(posedge clk) disable iff (sys_rst) s_q.oe4 == ~s_q.dir4;
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir)
        else $error("third port buffer disagrees with direction");

    property p_xtal_frees;
        @(posedge clk) disable iff (sys_rst)
            (s_q.clk_src == CLK_SRC_XTAL) |-> (s_q.oe2[3:2] == 2'b00) && (s_q.pe2[3:2] == 2'b00);
    endproperty
    a_xtal_frees: assert property (p_xtal_frees)
        else $error("oscillator pins driven as port");

    property p_ext_clk_in;
        @(posedge clk) disable iff (sys_rst) (s_q.clk_src == CLK_SRC_EXT) |-> !s_q.oe2[3];
    endproperty
    a_ext_clk_in: assert property (p_ext_clk_in)
        else $error("clock input pin driven");

    property p_pullup_input_only;
        @(posedge clk) disable iff (sys_rst) (s_q.pe4 & ~s_q.pu4) == 8'h00
            && (s_q.pe4 & ~s_q.dir4) == 8'h00;
    endproperty
    a_pullup_input_only: assert property (p_pullup_input_only)
        else $error("pull-up on output or unenabled bit");

    // Hold drops at the same edge that the option byte is taken
    property p_hold_before_opt;
        @(posedge clk) disable iff (sys_rst) (s_q.opt == OPT_WAIT) |-> s_q.hold;
    endproperty
    a_hold_before_opt: assert property (p_hold_before_opt)
        else $error("reset released before option read");

    property p_port_ignores_reset;
        @(posedge clk) disable iff (sys_rst)
            (s_q.opt == OPT_RUN && s_q.rst_is_port) ##1 (s_q.opt == OPT_RUN) |-> !s_q.hold;
    endproperty
    a_port_ignores_reset: assert property (p_port_ignores_reset)
        else $error("shared pin in port role still resets");

    property p_write_lands;
        @(posedge clk) disable iff (sys_rst)
            wr_en && idx == IDX_PORT_FOUR_DATA |=> s_q.lat4 == $past(pwdata[7:0]);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("latch write lost");

    // Driven level changed while the buffer stayed on
    property p_irq_on_change;
        @(posedge clk) disable iff (sys_rst)
            s_q.oe3 && $past(s_q.oe3) && $changed(s_q.lat3) |-> s_q.irq[1];
    endproperty
    a_irq_on_change: assert property (p_irq_on_change)
        else $error("no interrupt request on output change");

    property p_answer_one_wait;
        @(posedge clk) disable iff (sys_rst)
            psel && !penable ##1 psel && penable |=> pready;
    endproperty
    a_answer_one_wait: assert property (p_answer_one_wait)
        else $error("pready not one cycle into access");

endmodule // three_port_gpio

/* File: tb/pin_world.sv */
`timescale 1ns/1ps
module pin_world (
    // Clock
    input wire logic clk,
    // Board side: [3:0] first port, [4] second port, [12:5] third port
    input wire logic [12:0] ext_en,
    input wire logic [12:0] ext_val,
    input wire logic rst_lvl,
    // Device side
    input wire logic [12:0] oe,
    input wire logic [12:0] dout,
    input wire logic [12:0] pu,
    output logic [12:0] pin,
    output logic rst_pin
);
    logic [12:0] noise_q = 13'h0AAA;

    // Undriven lines wander, so a stale level is never read as valid
    always @(posedge clk) noise_q <= ~noise_q;

    // Device driver wins, then board device, then pull-up
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            pin[i] = oe[i] ? dout[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : noise_q[i];
        end
    end

    // Board resistor holds the shared pin high unless pulled low
    assign rst_pin = rst_lvl;
endmodule // pin_world

/* File: tb/three_port_gpio_tb.sv */
`timescale 1ns/1ps
module three_port_gpio_tb;
    import gpio_pkg::*;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, rst_lvl = 1;
    logic [7:0] option_byte = 8'h00, rd, m2;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'h0, p2_out, p2_oe, p2_pu;
    logic pready, pslverr, io_out, io_oe, io_pu, irq1, irq2, hold, er, rst_pin;
    logic [7:0] p4_out, p4_oe, p4_pu, dv[3], lv[3], uv[3];
    logic [1:0] clock_source;
    logic [12:0] ext_en = '1, ext_val = '0;
    logic [7:0] msk[3] = '{8'h0F, 8'h04, 8'hFF};
    logic [7:0] ro[3] = '{8'h00, 8'h10, 8'h00};
    wire [12:0] pin_w;
    wire [7:0] oe_v[3], out_v[3], pu_v[3], pin_v[3];
    int failures = 0, cmp_count = 0, cycles = 0, irq_cnt1 = 0, irq_cnt2 = 0;
    integer seed = 32'hc64027e7;

    // Per-port views of the pins
    assign oe_v = '{{4'h0, p2_oe}, {5'h0, io_oe, 2'h0}, p4_oe};
    assign out_v = '{{4'h0, p2_out}, {5'h0, io_out, 2'h0}, p4_out};
    assign pu_v = '{{4'h0, p2_pu}, {5'h0, io_pu, 2'h0}, p4_pu};
    assign pin_v = '{{4'h0, pin_w[3:0]}, {3'h0, rst_pin, 1'b0, pin_w[4], 2'h0}, pin_w[12:5]};

    three_port_gpio i_three_port_gpio (.clk(clk), .sys_rst(sys_rst), .option_byte(option_byte),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_two_pin_in(pin_w[3:0]), .port_two_pin_out(p2_out), .port_two_pin_oe(p2_oe),
        .port_two_pullup_en(p2_pu), .second_port_io_in(pin_w[4]), .second_port_io_out(io_out),
        .second_port_io_oe(io_oe), .second_port_io_pullup_en(io_pu),
        .shared_reset_input_in(rst_pin), .port_four_pin_in(pin_w[12:5]),
        .port_four_pin_out(p4_out), .port_four_pin_oe(p4_oe), .port_four_pullup_en(p4_pu),
        .ext_irq_first_req(irq1), .ext_irq_second_req(irq2), .system_reset_hold(hold),
        .clock_source(clock_source));

    pin_world i_pin_world (.clk(clk), .ext_en(ext_en), .ext_val(ext_val), .rst_lvl(rst_lvl),
        .oe({p4_oe, io_oe, p2_oe}), .dout({p4_out, io_out, p2_out}),
        .pu({p4_pu, io_pu, p2_pu}), .pin(pin_w), .rst_pin(rst_pin));

    // Clock
    initial forever #4 clk = ~clk;

    // Interrupt pulse counting and hang guard
    always @(posedge clk) begin
        cycles++;
        if (irq1 === 1'b1) irq_cnt1++;
        if (irq2 === 1'b1) irq_cnt2++;
        if (cycles > 30000) begin
            failures++;
            summarize();
        end
    end

    function automatic logic [7:0] exp_rd(input logic [7:0] d, l, p, m);
        return ((d & p) | (~d & l)) & m;
    endfunction

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task summarize;
        $display("Checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer; idle cycle before setup avoids double drive
    task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        pstrb <= 4'hF;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // If pready never rises, only the bench's cycle guard ends this wait
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task do_reset(input logic [7:0] opt);
        @(posedge clk);
        sys_rst <= 1'b1;
        option_byte <= opt;
        ext_val <= 13'($random(seed));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task wait_hold;
        int n;
        n = 0;
        while (hold !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Main sequence
    initial begin
        for (int s = 2; s >= 0; s--) begin
            do_reset({5'h0, 1'b1, 2'(s)});
            wait_hold();
            chk("hold", 8'h00, {7'h0, hold});
            chk("clock source", 8'(s), {6'h0, clock_source});
            apb(1'b0, IDX_PIN_CONFIG_STATUS, 8'h00);
            chk("status", 8'h0C | 8'(s), rd);
            m2 = s == 2 ? 8'(P2_MASK_EXT) : s == 1 ? 8'(P2_MASK_XTAL) : 8'(P2_MASK_HSI);
            chk("latch reset", 8'h00, {3'h0, io_out, p2_out} | p4_out);
            for (int r = 0; r < 3; r++) begin
                apb(1'b0, IDX_PORT_TWO_DIRECTION + 16'(r), 8'h00);
                chk("dir reset", DIR_RST, rd);
                apb(1'b0, IDX_PORT_TWO_PULLUP_ENABLE + 16'(r), 8'h00);
                chk("pullup reset", PU_RST, rd);
                apb(1'b0, IDX_PORT_TWO_DATA + 16'(r), 8'h00);
                chk("data reset", pin_v[r] & (r == 0 ? m2 : msk[r] | ro[r]), rd);
            end
            apb(1'b1, IDX_PORT_TWO_DIRECTION, 8'h00);
            apb(1'b1, IDX_PORT_TWO_DATA, 8'h0F);
            apb(1'b0, IDX_PORT_TWO_DATA, 8'h00);
            chk("clock pin read", m2, rd);
            chk("clock pin drive", m2, oe_v[0]);
        end
        // Random port settings, read back against pins
        repeat (60) begin
            for (int r = 0; r < 3; r++) begin
                dv[r] = 8'($random(seed));
                lv[r] = 8'($random(seed));
                uv[r] = 8'($random(seed));
                apb(1'b1, IDX_PORT_TWO_DIRECTION + 16'(r), dv[r]);
                apb(1'b1, IDX_PORT_TWO_DATA + 16'(r), lv[r]);
                apb(1'b1, IDX_PORT_TWO_PULLUP_ENABLE + 16'(r), uv[r]);
            end
            ext_val <= 13'($random(seed));
            repeat (3) @(posedge clk);
            for (int r = 0; r < 3; r++) begin
                apb(1'b0, IDX_PORT_TWO_DIRECTION + 16'(r), 8'h00);
                chk("dir", dv[r] | ~msk[r], rd);
                apb(1'b0, IDX_PORT_TWO_DATA + 16'(r), 8'h00);
                chk("data", exp_rd(dv[r], lv[r], pin_v[r], msk[r]) | pin_v[r] & ro[r], rd);
                apb(1'b0, IDX_PORT_TWO_PULLUP_ENABLE + 16'(r), 8'h00);
                chk("pullup", uv[r] & msk[r], rd);
                chk("enable", ~dv[r] & msk[r], oe_v[r]);
                chk("latch", lv[r] & msk[r], out_v[r]);
                chk("pullup pin", uv[r] & dv[r] & msk[r], pu_v[r]);
            end
        end
        // Third port floating, held by its own pull-ups
        ext_en <= 13'h001F;
        apb(1'b1, IDX_PORT_FOUR_DIRECTION, 8'hFF);
        apb(1'b1, IDX_PORT_FOUR_PULLUP_ENABLE, 8'hFF);
        repeat (3) @(posedge clk);
        apb(1'b0, IDX_PORT_FOUR_DATA, 8'h00);
        chk("pulled high", 8'hFF, rd);
        ext_en <= '1;
        ext_val <= '0;
        // Interrupt-shared bits: one pulse per real level change
        apb(1'b1, IDX_PORT_TWO_DATA, 8'h00);
        apb(1'b1, IDX_PORT_THREE_DATA, 8'h00);
        // Interrupt masks are taken as set before these bits become outputs
        apb(1'b1, IDX_PORT_TWO_DIRECTION, 8'hFD);
        apb(1'b1, IDX_PORT_THREE_DIRECTION, 8'hFB);
        repeat (3) @(posedge clk);
        irq_cnt1 = 0;
        irq_cnt2 = 0;
        repeat (2) begin
            apb(1'b1, IDX_PORT_TWO_DATA, 8'h02);
            apb(1'b1, IDX_PORT_THREE_DATA, 8'h04);
        end
        repeat (3) @(posedge clk);
        chk("irq first", 8'h01, 8'(irq_cnt1));
        chk("irq second", 8'h01, 8'(irq_cnt2));
        apb(1'b0, 16'hFF10, 8'h00);
        chk("unmapped", 8'h01, {7'h0, er} | rd);
        // Shared pin in reset role, held low across option read
        rst_lvl <= 1'b0;
        do_reset(8'h00);
        repeat (20) @(posedge clk);
        chk("held", 8'h01, {7'h0, hold});
        rst_lvl <= 1'b1;
        wait_hold();
        chk("released", 8'h00, {7'h0, hold});
        do_reset(8'h04);
        wait_hold();
        rst_lvl <= 1'b0;
        repeat (4) @(posedge clk);
        chk("pin ignored", 8'h00, {7'h0, hold});
        apb(1'b0, IDX_PORT_THREE_DATA, 8'h00);
        chk("input only", 8'h00, rd & 8'h10);
        summarize();
    end
endmodule // three_port_gpio_tb
